// >>> sqh_cycle.sv
`timescale 1ns/1ps
// one bus cycle on the flash pins: read or write with enable timing
module sqh_cycle (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // request
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  // flash pins
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [21:0]      fa,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  input  wire logic [15:0] dq_i
);
  typedef enum logic [1:0] {SQH_C_IDLE, SQH_C_SETUP, SQH_C_PULSE, SQH_C_HOLD} sqh_cst_t;
  typedef struct packed {
    sqh_cst_t    st;
    logic [3:0]  cnt;
    logic        wr;
    logic        done;
    logic [15:0] rdata;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [21:0] fa;
    logic [15:0] dq_o;
    logic        dq_oe;
    logic [15:0] sync1;
    logic [15:0] sync2;
  } sqh_cyc_t;
  sqh_cyc_t s_r, s_nxt;

  ////////////////////////////////////////////////////////////////////
  // next state: setup, strobe, hold
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done  = 1'b0;
    s_nxt.sync1 = dq_i;
    s_nxt.sync2 = s_r.sync1;
    case (s_r.st)
      SQH_C_IDLE:
        if (start)
        begin
          s_nxt.st    = SQH_C_SETUP;
          s_nxt.wr    = is_write;
          s_nxt.fa    = addr;
          s_nxt.dq_o  = wdata;
          s_nxt.dq_oe = is_write;
          s_nxt.ce_n  = 1'b0;
          s_nxt.cnt   = 4'(sqh_pkg::SETUP_CYC);
        end
      SQH_C_SETUP:
        if (s_r.cnt > 4'h1)
          s_nxt.cnt = s_r.cnt - 4'h1;
        else
        begin
          // write strobe only with oe high
          s_nxt.st   = SQH_C_PULSE;
          s_nxt.we_n = ~s_r.wr;
          s_nxt.oe_n = s_r.wr;
          // strobe held well past glitch width
          s_nxt.cnt  = s_r.wr ? 4'(sqh_pkg::PULSE_CYC) : 4'(sqh_pkg::READ_CYC + 2);
        end
      SQH_C_PULSE:
        if (s_r.cnt > 4'h1)
          s_nxt.cnt = s_r.cnt - 4'h1;
        else
        begin
          s_nxt.st    = SQH_C_HOLD;
          s_nxt.we_n  = 1'b1;
          s_nxt.oe_n  = 1'b1;
          s_nxt.rdata = s_r.sync2;
          s_nxt.cnt   = 4'(sqh_pkg::HOLD_CYC);
        end
      SQH_C_HOLD:
        if (s_r.cnt > 4'h1)
          s_nxt.cnt = s_r.cnt - 4'h1;
        else
        begin
          s_nxt.st    = SQH_C_IDLE;
          s_nxt.ce_n  = 1'b1;
          s_nxt.dq_oe = 1'b0;
          s_nxt.done  = 1'b1;
        end
      default: s_nxt.st = SQH_C_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r       <= '0;
      s_r.ce_n  <= 1'b1;
      s_r.oe_n  <= 1'b1;
      s_r.we_n  <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign done  = s_r.done;
  assign rdata = s_r.rdata;
  assign ce_n  = s_r.ce_n;
  assign oe_n  = s_r.oe_n;
  assign we_n  = s_r.we_n;
  assign fa    = s_r.fa;
  assign dq_o  = s_r.dq_o;
  assign dq_oe = s_r.dq_oe;

  // never write and output at once
  chk_no_contention: assert property (@(posedge mclk) disable iff (!rst_n)
    !(!s_r.we_n && !s_r.oe_n)) else $error("we and oe both low");
  // write pulse lasts the full width
  chk_pulse_width: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(s_r.we_n) |-> !s_r.we_n [*2]) else $error("write pulse too short");
  // write strobe always under chip enable
  chk_we_under_ce: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_r.we_n |-> !s_r.ce_n && s_r.dq_oe) else $error("we low without ce or data");
  // every bus cycle finishes in bounded time
  chk_cycle_ends: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(start) && s_r.st == SQH_C_IDLE |-> ##[4:12] s_r.done) else $error("cycle hung");
endmodule

// >>> sqh_flash.sv
`timescale 1ns/1ps
// behavioural flash device: array, query table, secure region
module sqh_flash #(
  parameter bit SEC_LOCKED = 1'b0
) (
  // flash pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [21:0] fa,
  input  wire logic [15:0] dq_o,
  output logic [15:0]      dq
);
  logic [15:0] mem [0:255];
  logic [15:0] sec [0:127];
  logic [1:0]  mode;
  logic [1:0]  unlock;
  logic        exit_wait;
  logic        below_lockout;
  logic [21:0] wa;
  logic [15:0] last;
  realtime     t_fall;

  // power-up lands in array read mode
  initial
  begin
    mode = 2'd0;
    unlock = 2'd0;
    exit_wait = 1'b0;
    below_lockout = 1'b0;
    last = 16'h0000;
  end

  function automatic logic [15:0] qword(input logic [21:0] a);
    case (a)
      22'h10: return 16'h0051;
      22'h11: return 16'h0052;
      22'h12: return 16'h0059;
      22'h13: return 16'h0002;
      22'h15: return 16'h0040;
      22'h1b: return 16'h0027;
      22'h1c: return 16'h0031;
      22'h1f: return 16'h0004;
      22'h21: return 16'h0009;
      22'h23: return 16'h0005;
      22'h25: return 16'h0004;
      default: return 16'h0000;
    endcase
  endfunction

  // command decode, no bypass in region
  // below the lockout threshold writes drop, array reads
  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    if (below_lockout)
    begin
      mode = 2'd0;
      unlock = 2'd0;
      exit_wait = 1'b0;
    end
    else if (d == 16'h00f0)
    begin
      mode = 2'd0;
      unlock = 2'd0;
      exit_wait = 1'b0;
    end
    else if (exit_wait)
    begin
      mode = 2'd0;
      exit_wait = 1'b0;
    end
    else if (unlock == 2'd2)
    begin
      unlock = 2'd0;
      if (d == 16'h0088)
        mode = 2'd2;
      else if (d == 16'h0090 && mode == 2'd2)
        exit_wait = 1'b1;
      // identifier mode, left by reset or by the query command
      else if (d == 16'h0090)
        mode = 2'd3;
    end
    else if (d == 16'h00aa && a == 22'h000555)
      unlock = 2'd1;
    else if (d == 16'h0055 && a == 22'h0002aa && unlock == 2'd1)
      unlock = 2'd2;
    else if (d == 16'h0098 && a == 22'h000055 && (mode == 2'd0 || mode == 2'd3))
      mode = 2'd1;
    else if (mode == 2'd2)
    begin
      if (a <= 22'h00007f && !SEC_LOCKED)
        sec[a[6:0]] = d;
    end
    else if (mode == 2'd0)
      mem[a[7:0]] = d;
  endtask

  // address taken at the falling write edge
  always @(negedge we_n)
  begin
    t_fall = $realtime;
    if (!ce_n && oe_n)
      wa = fa;
  end

  // short pulses and wrong enables start no write
  always @(posedge we_n)
    if (!ce_n && oe_n && ($realtime - t_fall) >= 5.0)
      wr(wa, dq_o);

  // reads: region words any number of times, query table or array
  // released bus shows the inverse of the last word
  always @(ce_n, oe_n, fa, mode)
    if (!ce_n && !oe_n)
    begin
      if (mode == 2'd1)
        dq = qword(fa);
      else if (mode == 2'd2 && fa <= 22'h00007f)
        dq = sec[fa[6:0]];
      else
        dq = mem[fa[7:0]];
      last = dq;
    end
    else
      dq = ~last;
endmodule

// >>> sqh_host.sv
`timescale 1ns/1ps
// host controller: query table, secure region entry/exit, array access
module sqh_host (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // user request
  input  wire logic        req,
  input  wire logic [2:0]  op,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        pwd_mode,
  input  wire logic        dev_busy,
  output logic             ack,
  output logic             refused,
  output logic [15:0]      rdata,
  output logic             in_query,
  output logic             in_region,
  output logic             idle,
  // flash pins
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic [21:0]      fa,
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  input  wire logic [15:0] dq_i
);
  typedef enum logic [1:0] {SQH_IDLE, SQH_RUN, SQH_WAIT} sqh_st_t;
  typedef struct packed {
    logic [1:0]  busy_sync;
    sqh_st_t     st;
    logic [1:0]  step;
    logic [1:0]  nsteps;
    sqh_pkg::sqh_op_t op;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic        start;
    logic        ack;
    logic        refused;
    logic [15:0] rdata;
    logic        query;
    logic        region;
    logic        idle;
  } sqh_host_t;
  sqh_host_t s_r, s_nxt;

  logic        rst_n;
  logic [1:0]  rst_sync_r;
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic [21:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic        cyc_wr;

  ////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////
  // per-step address and data of each command sequence
  always_comb
  begin
    cyc_wr    = 1'b1;
    cyc_addr  = s_r.addr;
    cyc_wdata = s_r.wdata;
    case (s_r.op)
      // query command word at its address
      sqh_pkg::SQH_OP_QUERY:
      begin
        cyc_addr  = sqh_pkg::ADDR_QUERY;
        cyc_wdata = sqh_pkg::CMD_QUERY;
      end
      // reset word, address left as given
      sqh_pkg::SQH_OP_RESET: cyc_wdata = sqh_pkg::CMD_RESET;
      // three-cycle region entry and four-cycle region exit sequences
      sqh_pkg::SQH_OP_REGION_IN, sqh_pkg::SQH_OP_REGION_OUT:
        case (s_r.step)
          2'h0:
          begin
            cyc_addr  = sqh_pkg::ADDR_UNLOCK1;
            cyc_wdata = sqh_pkg::CMD_UNLOCK1;
          end
          2'h1:
          begin
            cyc_addr  = sqh_pkg::ADDR_UNLOCK2;
            cyc_wdata = sqh_pkg::CMD_UNLOCK2;
          end
          2'h2:
          begin
            cyc_addr  = sqh_pkg::ADDR_UNLOCK1;
            cyc_wdata = (s_r.op == sqh_pkg::SQH_OP_REGION_IN) ?
                        sqh_pkg::CMD_REGION_IN : sqh_pkg::CMD_REGION_OUT;
          end
          default:
          begin
            cyc_addr  = '0;
            cyc_wdata = sqh_pkg::CMD_EXIT2;
          end
        endcase
      sqh_pkg::SQH_OP_READ: cyc_wr = 1'b0;
      default: cyc_wr = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // request sequencing and mode tracking
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.busy_sync = {s_r.busy_sync[0], dev_busy};
    s_nxt.start   = 1'b0;
    s_nxt.ack     = 1'b0;
    s_nxt.refused = 1'b0;
    case (s_r.st)
      SQH_IDLE:
        if (req)
        begin
          s_nxt.op    = sqh_pkg::sqh_op_t'(op);
          s_nxt.addr  = addr;
          s_nxt.wdata = wdata;
          s_nxt.step  = 2'h0;
          s_nxt.nsteps = (op == 3'(sqh_pkg::SQH_OP_REGION_IN)) ? 2'h2 :
                         (op == 3'(sqh_pkg::SQH_OP_REGION_OUT)) ? 2'h3 : 2'h0;
          // no query while embedded op runs
          if (op == 3'(sqh_pkg::SQH_OP_QUERY) && s_r.busy_sync[1])
            s_nxt.refused = 1'b1;
          // array write inside region is refused
          else if (op == 3'(sqh_pkg::SQH_OP_WRITE) && s_r.region &&
                   addr > sqh_pkg::SEC_LAST)
            s_nxt.refused = 1'b1;
          // password mode keeps low words off limits
          else if (op == 3'(sqh_pkg::SQH_OP_WRITE) && s_r.region && pwd_mode &&
                   addr < sqh_pkg::SEC_FIRST_PWD)
            s_nxt.refused = 1'b1;
          else if (op > 3'(sqh_pkg::SQH_OP_REGION_OUT))
            s_nxt.refused = 1'b1;
          else
          begin
            s_nxt.st    = SQH_RUN;
            s_nxt.start = 1'b1;
          end
        end
      SQH_RUN:
        s_nxt.st = SQH_WAIT;
      SQH_WAIT:
        if (cyc_done)
        begin
          if (s_r.step != s_r.nsteps)
          begin
            s_nxt.step  = s_r.step + 2'h1;
            s_nxt.st    = SQH_RUN;
            s_nxt.start = 1'b1;
          end
          else
          begin
            s_nxt.st  = SQH_IDLE;
            s_nxt.ack = 1'b1;
            // query data low byte, upper zeroed
            s_nxt.rdata = s_r.query ? {8'h00, cyc_rdata[7:0]} : cyc_rdata;
            case (s_r.op)
              sqh_pkg::SQH_OP_QUERY: s_nxt.query = 1'b1;
              sqh_pkg::SQH_OP_RESET: s_nxt.query = 1'b0;
              // boot addresses map to secure sector
              sqh_pkg::SQH_OP_REGION_IN: s_nxt.region = 1'b1;
              sqh_pkg::SQH_OP_REGION_OUT: s_nxt.region = 1'b0;
              default: s_nxt.query = s_r.query;
            endcase
          end
        end
      default: s_nxt.st = SQH_IDLE;
    endcase
    // idle kept in a flop so the output needs no decode
    s_nxt.idle = (s_nxt.st == SQH_IDLE);
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r.busy_sync <= 2'h0;
      s_r.st        <= SQH_IDLE;
      s_r.step      <= 2'h0;
      s_r.nsteps    <= 2'h0;
      s_r.op        <= sqh_pkg::SQH_OP_READ;
      s_r.addr      <= '0;
      s_r.wdata     <= '0;
      s_r.start     <= 1'b0;
      s_r.ack       <= 1'b0;
      s_r.refused   <= 1'b0;
      s_r.rdata     <= '0;
      s_r.query     <= 1'b0;
      s_r.region    <= 1'b0;
      s_r.idle      <= 1'b1;
    end
    else
    begin
      s_r.busy_sync <= s_nxt.busy_sync;
      s_r.st        <= s_nxt.st;
      s_r.step      <= s_nxt.step;
      s_r.nsteps    <= s_nxt.nsteps;
      s_r.op        <= s_nxt.op;
      s_r.addr      <= s_nxt.addr;
      s_r.wdata     <= s_nxt.wdata;
      s_r.start     <= s_nxt.start;
      s_r.ack       <= s_nxt.ack;
      s_r.refused   <= s_nxt.refused;
      s_r.rdata     <= s_nxt.rdata;
      s_r.query     <= s_nxt.query;
      s_r.region    <= s_nxt.region;
      s_r.idle      <= s_nxt.idle;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin sequencer
  sqh_cycle u_cycle (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .start    (s_r.start),
    .is_write (cyc_wr),
    .addr     (cyc_addr),
    .wdata    (cyc_wdata),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .ce_n     (ce_n),
    .oe_n     (oe_n),
    .we_n     (we_n),
    .fa       (fa),
    .dq_o     (dq_o),
    .dq_oe    (dq_oe),
    .dq_i     (dq_i)
  );

  assign ack       = s_r.ack;
  assign refused   = s_r.refused;
  assign rdata     = s_r.rdata;
  assign in_query  = s_r.query;
  assign in_region = s_r.region;
  assign idle      = s_r.idle;

  // query command lands at 55h with 98h
  chk_query_cmd: assert property (@(posedge mclk) disable iff (!rst_n)
    !we_n && s_r.op == sqh_pkg::SQH_OP_QUERY |->
    fa == sqh_pkg::ADDR_QUERY && dq_o == sqh_pkg::CMD_QUERY) else $error("bad query cycle");
  chk_query_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    s_r.st == SQH_IDLE && req && op == 3'(sqh_pkg::SQH_OP_QUERY) && s_r.busy_sync[1]
    |=> refused && !s_r.start) else $error("query sent while busy");
  // reset clears query flag on ack
  chk_reset_exit: assert property (@(posedge mclk) disable iff (!rst_n)
    ack && s_r.op == sqh_pkg::SQH_OP_RESET |-> !in_query) else $error("query not left");
  // upper byte zero in query mode
  chk_query_byte: assert property (@(posedge mclk) disable iff (!rst_n)
    ack && $past(s_r.query) |-> rdata[15:8] == 8'h00) else $error("upper byte set");
endmodule

// >>> sqh_host_tb.sv
`timescale 1ns/1ps
module sqh_host_tb;
  logic        mclk;
  logic        reset_n;
  logic        req;
  logic [2:0]  op;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic        pwd_mode;
  logic        dev_busy;
  logic        ack;
  logic        refused;
  logic [15:0] rdata;
  logic        in_query;
  logic        in_region;
  logic        idle;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic [21:0] fa;
  logic [15:0] dq_o;
  logic        dq_oe;
  logic [15:0] dq_i;
  logic [15:0] rd;
  logic        rf;
  int          num_errors;
  int          checked;
  int          cycles;
  logic [15:0] qexp [0:22] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0031, 16'h0000,
    16'h0000, 16'h0004, 16'h0000, 16'h0009, 16'h0000, 16'h0005, 16'h0000, 16'h0004, 16'h0000};

  sqh_host dut (.mclk(mclk), .reset_n(reset_n), .req(req), .op(op), .addr(addr),
    .wdata(wdata), .pwd_mode(pwd_mode), .dev_busy(dev_busy), .ack(ack), .refused(refused),
    .rdata(rdata), .in_query(in_query), .in_region(in_region), .idle(idle), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .fa(fa), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
  sqh_flash flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .fa(fa), .dq_o(dq_o), .dq(dq_i));

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one request, held until taken, then wait for ack or refusal
  task automatic do_op(input logic [2:0] o, input logic [21:0] a, input logic [15:0] d);
    int n;
    n = 0;
    // one edge between requests so req never toggles in one time step
    @(posedge mclk);
    #1;
    while (idle !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    req = 1'b1;
    op = o;
    addr = a;
    wdata = d;
    @(posedge mclk);
    #1;
    req = 1'b0;
    n = 0;
    while (ack !== 1'b1 && refused !== 1'b1 && n < 200)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    rf = refused;
    rd = rdata;
    check({15'h0, n < 200}, 16'h0001);
  endtask

  // query entry and the whole table
  task automatic s_query;
    do_op(3'd1, 22'h000020, 16'h1234);
    do_op(3'd2, 22'h000055, 16'h0000);
    check({14'h0, rf, in_query}, 16'h0001);
    for (int i = 0; i < 23; i++)
    begin
      do_op(3'd0, 22'(16 + i), 16'h0000);
      check(rd, qexp[i]);
    end
  endtask

  // reset with odd address returns array reads
  task automatic s_reset;
    do_op(3'd3, 22'h3abcde, 16'h0000);
    check({14'h0, flash.mode}, 16'h0000);
    do_op(3'd0, 22'h000020, 16'h0000);
    check(rd, 16'h1234);
  endtask

  // query refused while an embedded op runs
  task automatic s_busy;
    dev_busy = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    do_op(3'd2, 22'h000055, 16'h0000);
    check({14'h0, rf, in_query}, 16'h0002);
    dev_busy = 1'b0;
  endtask

  // secure region: bounds in both modes, mapping, exit
  task automatic s_region;
    do_op(3'd4, 22'h000000, 16'h0000);
    check({14'h0, in_region, flash.mode == 2'd2}, 16'h0003);
    do_op(3'd1, 22'h000000, 16'h5a5a);
    do_op(3'd1, 22'h00007f, 16'ha5a5);
    do_op(3'd0, 22'h000000, 16'h0000);
    check(rd, 16'h5a5a);
    do_op(3'd0, 22'h00007f, 16'h0000);
    check(rd, 16'ha5a5);
    pwd_mode = 1'b1;
    do_op(3'd1, 22'h000004, 16'h1111);
    check({15'h0, rf}, 16'h0001);
    do_op(3'd1, 22'h000080, 16'h1111);
    check({15'h0, rf}, 16'h0001);
    do_op(3'd1, 22'h000005, 16'h2222);
    check({15'h0, rf}, 16'h0000);
    pwd_mode = 1'b0;
    do_op(3'd5, 22'h000000, 16'h0000);
    check({14'h0, in_region, flash.mode == 2'd0}, 16'h0001);
    do_op(3'd0, 22'h000020, 16'h0000);
    check(rd, 16'h1234);
  endtask

  // query accepted from identifier mode, reset leaves it
  task automatic s_ident;
    do_op(3'd1, 22'h000555, 16'h00aa);
    do_op(3'd1, 22'h0002aa, 16'h0055);
    do_op(3'd1, 22'h000555, 16'h0090);
    check({14'h0, flash.mode}, 16'h0003);
    do_op(3'd2, 22'h000055, 16'h0000);
    do_op(3'd0, 22'h000010, 16'h0000);
    check(rd, 16'h0051);
    do_op(3'd3, 22'h000000, 16'h0000);
    check({14'h0, flash.mode}, 16'h0000);
  endtask

  // low supply: the write is dropped, array data kept
  task automatic s_lockout;
    flash.below_lockout = 1'b1;
    do_op(3'd1, 22'h000020, 16'hdead);
    flash.below_lockout = 1'b0;
    do_op(3'd0, 22'h000020, 16'h0000);
    check(rd, 16'h1234);
  endtask

  // reset while idle after a query parks the pins and drops query tracking
  task automatic s_midreset;
    do_op(3'd2, 22'h000055, 16'h0000);
    check({15'h0, in_query}, 16'h0001);
    reset_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check({11'h0, in_query, ce_n, oe_n, we_n, dq_oe}, 16'h000e);
    reset_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    do_op(3'd3, 22'h000000, 16'h0000);
    check({14'h0, flash.mode, in_query}, 16'h0000);
  endtask

  // unknown operation codes start no bus cycle
  task automatic s_bad_op;
    do_op(3'd6, 22'h0, 16'h0);
    check({15'h0, rf}, 16'h0001);
    do_op(3'd7, 22'h0, 16'h0);
    check({15'h0, rf}, 16'h0001);
  endtask

  // write strobe only with chip enabled and output off; no contention
  always @(negedge mclk)
    if (reset_n === 1'b1 && we_n === 1'b0)
      check({15'h0, oe_n & ~ce_n & dq_oe}, 16'h0001);

  // clock and hang limit
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      num_errors++;
      close_out;
    end
  end

  initial
  begin
    reset_n = 1'b0;
    req = 1'b0;
    op = 3'd0;
    addr = 22'h0;
    wdata = 16'h0;
    pwd_mode = 1'b0;
    dev_busy = 1'b0;
    num_errors = 0;
    checked = 0;
    cycles = 0;
    repeat (12) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    s_query;
    s_reset;
    s_busy;
    s_region;
    s_ident;
    s_lockout;
    s_midreset;
    s_bad_op;
    close_out;
  end
endmodule

// >>> sqh_pkg.sv
// Summary of operation
// - host locks via entry sequence, protect algorithm; the host has no lock operation
// - host exits region before touching array; in region the host refuses array writes and, with pwd_mode, writes below 05h; array reads pass
// - write needs ce and we low, oe high
// - write 98h at 55h enters query mode
// - reset command leaves query mode
package sqh_pkg;
  // command words and addresses
  localparam logic [15:0] CMD_QUERY      = 16'h0098;
  localparam logic [15:0] CMD_RESET      = 16'h00f0;
  localparam logic [15:0] CMD_UNLOCK1    = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2    = 16'h0055;
  localparam logic [15:0] CMD_REGION_IN  = 16'h0088;
  localparam logic [15:0] CMD_REGION_OUT = 16'h0090;
  localparam logic [15:0] CMD_EXIT2      = 16'h0000;
  localparam logic [21:0] ADDR_QUERY     = 22'h000055;
  localparam logic [21:0] ADDR_UNLOCK1   = 22'h000555;
  localparam logic [21:0] ADDR_UNLOCK2   = 22'h0002aa;
  // secure sector bounds
  localparam logic [21:0] SEC_FIRST_PERS = 22'h000000;
  localparam logic [21:0] SEC_FIRST_PWD  = 22'h000005;
  localparam logic [21:0] SEC_LAST       = 22'h00007f;
  // query table entries
  localparam logic [7:0] Q_SIG_ADDR  = 8'h10;
  localparam logic [7:0] Q_LAST_ADDR = 8'h26;
  // bus timing, 40 MHz clock
  localparam int CLK_NS      = 25;
  localparam int SETUP_NS    = 25;
  localparam int PULSE_NS    = 50;
  localparam int HOLD_NS     = 25;
  localparam int READ_NS     = 75;
  localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC    = (READ_NS + CLK_NS - 1) / CLK_NS;
  // host operations
  typedef enum logic [2:0] {
    SQH_OP_READ, SQH_OP_WRITE, SQH_OP_QUERY, SQH_OP_RESET,
    SQH_OP_REGION_IN, SQH_OP_REGION_OUT
  } sqh_op_t;
endpackage
